// ===== asc_defines.svh
// Purpose: constants for the converter sample control block
// Assumes: 100 MHz hclk, word-aligned AHB-Lite register map
// Notes:   offsets are byte addresses
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define ASC_OFF_CTRL    8'h00
`define ASC_OFF_STATUS  8'h04
`define ASC_OFF_DATA    8'h08

// ****************************************
// control fields
// ****************************************
`define ASC_CTRL_EN       0
`define ASC_CTRL_MODE_LO  1
`define ASC_CTRL_CH_LO    4
`define ASC_CTRL_RNG_LO   8
`define ASC_CTRL_REF      10
`define ASC_CTRL_RST      32'h0000_0000

// ****************************************
// timing
// ****************************************
`define ASC_CLK_MHZ       100
`define ASC_CONV_NS       10000
`define ASC_NUM_CH        9

// ****************************************
// per-mode sample period (ns) and settling wait (us)
// ****************************************
`define ASC_PER0_NS       170678
`define ASC_PER1_NS       85471
`define ASC_PER2_NS       21334
`define ASC_PER3_NS       10667
`define ASC_PER4_NS       5348
`define ASC_SET0_US       171
`define ASC_SET1_US       85
`define ASC_SET2_US       21
`define ASC_SET3_US       11
`define ASC_SET4_US       5

`endif

// ===== asc_pkg.sv
// Purpose: types for the converter sample control block
// Assumes: nothing
// Notes:   mode codes 0 to 4 pick the rate and settling time
package asc_pkg;
   typedef enum logic [2:0] {
      ASC_M0 = 3'b000,
      ASC_M1 = 3'b001,
      ASC_M2 = 3'b010,
      ASC_M3 = 3'b011,
      ASC_M4 = 3'b100
   } asc_mode_t;

   typedef enum logic [1:0] {
      ASC_R36 = 2'b00,
      ASC_R24 = 2'b01,
      ASC_R12 = 2'b10
   } asc_range_t;

   typedef enum logic [1:0] {
      ASC_IDLE   = 2'b00,
      ASC_SETTLE = 2'b01,
      ASC_CONV   = 2'b10,
      ASC_GAP    = 2'b11
   } asc_state_t;
endpackage : asc_pkg

// ===== asc_fifo.sv
// Purpose: small sample buffer with valid/ready on both sides
// Assumes: single clock
// Notes:   flop storage addressed by index
`timescale 1ns/1ps
module asc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   input  wire logic             flush
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wp_q, wp_d, rp_q, rp_d;
   logic             push, pop;

   // full and empty from pointer wrap bit
   assign in_ready  = !((wp_q[AW] != rp_q[AW]) &&
                        (wp_q[AW-1:0] == rp_q[AW-1:0]));
   assign out_valid = (wp_q != rp_q);
   assign out_data  = mem_q[rp_q[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // next pointers
   always_comb begin
      wp_d = wp_q;
      rp_d = rp_q;
      if (flush) begin
         wp_d = '0;
         rp_d = '0;
      end else begin
         if (push) wp_d = wp_q + 1'b1;
         if (pop)  rp_d = rp_q + 1'b1;
      end
   end

   // pointer registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
   end

   // storage write
   always_ff @(posedge hclk) begin
      if (push && !flush) mem_q[wp_q[AW-1:0]] <= in_data;
   end
endmodule // asc_fifo

// ===== asc_ctrl.sv
// Purpose: sequencing and sample path around the analog converter core
// Assumes: AHB-Lite slave, 100 MHz hclk, core raw word is async to hclk
// Notes:   core handshake level pins pass two flops before use
//
// What this block does
// - samples delivered as 16-bit words
// - nine input channels, one routed at once
// - each conversion ends within ten microseconds
// - starts never faster than 187 kHz
// - raw core output processed into valid samples
// - logic drives input and reference multiplexers
// - reference selectable supply or bandgap
// - three input ranges applied to core
// - five modes set maximum sample rate
// - settling latency after switch before valid sample
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_ctrl #(
   parameter int FIFO_DEPTH = 4,
   parameter int SETTLE0_US = `ASC_SET0_US
) (
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   output logic      [3:0]            core_ch_sel,
   output logic                       core_ref_bg,
   output asc_pkg::asc_range_t        core_range,
   output logic                       core_start,
   input  wire logic                  core_done,
   input  wire logic [15:0]           core_raw
);
   import asc_pkg::*;

   // refuse parameter values the logic cannot serve
   initial begin
      if (FIFO_DEPTH < 2) $error("fifo depth too small");
      if (SETTLE0_US < 1) $error("settle time too small");
   end

   // ****************************************
   // timing helpers
   // ****************************************
   // sample period in cycles per mode, rounded up so rate never exceeds max
   function automatic logic [19:0] period_cyc(input asc_mode_t m);
      int ns;
      unique case (m)
         ASC_M0:  ns = `ASC_PER0_NS;   // 5.859 kHz
         ASC_M1:  ns = `ASC_PER1_NS;   // 11.7 kHz
         ASC_M2:  ns = `ASC_PER2_NS;   // 46.875 kHz
         ASC_M3:  ns = `ASC_PER3_NS;   // 93.75 kHz
         default: ns = `ASC_PER4_NS;   // 187 kHz
      endcase
      period_cyc = 20'((ns * `ASC_CLK_MHZ + 999) / 1000);
   endfunction

   // settling latency per mode in cycles
   function automatic logic [19:0] settle_cyc(input asc_mode_t m);
      int us;
      unique case (m)
         ASC_M0:  us = SETTLE0_US;
         ASC_M1:  us = `ASC_SET1_US;
         ASC_M2:  us = `ASC_SET2_US;
         ASC_M3:  us = `ASC_SET3_US;
         default: us = `ASC_SET4_US;
      endcase
      settle_cyc = 20'(us * `ASC_CLK_MHZ);
   endfunction

   // conversion timeout in cycles
   localparam logic [19:0] CONV_CYC =
      20'(`ASC_CONV_NS * `ASC_CLK_MHZ / 1000);

   // ****************************************
   // bus slave
   // ****************************************
   logic        ap_wr_q, ap_wr_d, rd_go;
   logic [7:0]  ap_addr_q, ap_addr_d;
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] rdata_q, rdata_d;
   logic        ovf_q, ovf_d;
   logic        cfg_chg;
   logic        data_rd;
   logic [15:0] fifo_dout;
   logic        fifo_valid;
   logic        fifo_in_ready;
   logic        push;
   logic [15:0] sample_q, sample_d;
   asc_state_t  st_q, st_d;

   // taken address phase and decoded settings
   wire         ap_go = hsel && hready && htrans[1];
   wire         en    = ctrl_q[`ASC_CTRL_EN];
   wire asc_mode_t mode_sel = asc_mode_t'(ctrl_q[`ASC_CTRL_MODE_LO +: 3]);

   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   // register the address phase, build read data for the data phase
   always_comb begin
      ap_wr_d   = ap_go && hwrite;
      rd_go     = ap_go && !hwrite;
      ap_addr_d = ap_go ? haddr[7:0] : ap_addr_q;
      ctrl_d    = ctrl_q;
      rdata_d   = 32'h0000_0000;
      data_rd   = 1'b0;
      cfg_chg   = 1'b0;
      if (ap_wr_q && ap_addr_q == `ASC_OFF_CTRL) begin
         ctrl_d  = {21'h0, hwdata[10:0]};
         // clamp illegal channel, mode and range codes
         if (hwdata[`ASC_CTRL_CH_LO +: 4] >= 4'(`ASC_NUM_CH))
            ctrl_d[`ASC_CTRL_CH_LO +: 4] = 4'h8;
         if (hwdata[`ASC_CTRL_MODE_LO +: 3] > 3'h4)
            ctrl_d[`ASC_CTRL_MODE_LO +: 3] = 3'h4;
         if (hwdata[`ASC_CTRL_RNG_LO +: 2] == 2'h3)
            ctrl_d[`ASC_CTRL_RNG_LO +: 2] = 2'h2;
         cfg_chg = (ctrl_d != ctrl_q);
      end
      if (rd_go) begin
         unique case (haddr[7:0])
            `ASC_OFF_CTRL:   rdata_d = ctrl_q;
            `ASC_OFF_STATUS: rdata_d = {28'h0000000, ovf_q,
                                        (st_q == ASC_SETTLE),
                                        !fifo_in_ready, fifo_valid};
            `ASC_OFF_DATA: begin
               rdata_d = {16'h0000, fifo_valid ? fifo_dout : 16'h0000};
               data_rd = fifo_valid;
            end
            default:         rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // bus state registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_q   <= 1'b0;
         ap_addr_q <= 8'h00;
         ctrl_q    <= `ASC_CTRL_RST;
         rdata_q   <= 32'h0000_0000;
      end else begin
         ap_wr_q   <= ap_wr_d;
         ap_addr_q <= ap_addr_d;
         ctrl_q    <= ctrl_d;
         rdata_q   <= rdata_d;
      end
   end

   // ****************************************
   // core interface
   // ****************************************
   // mux selects follow the settings directly
   assign core_ch_sel = ctrl_q[`ASC_CTRL_CH_LO +: 4];
   assign core_ref_bg = ctrl_q[`ASC_CTRL_REF];
   assign core_range  = asc_range_t'(ctrl_q[`ASC_CTRL_RNG_LO +: 2]);

   // two-flop sync of the done level, then edge detect
   logic done_s1_q, done_s2_q, done_s3_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         done_s3_q <= 1'b0;
      end else begin
         done_s1_q <= core_done;
         done_s2_q <= done_s1_q;
         done_s3_q <= done_s2_q;
      end
   end
   // one-cycle pulse on the synchronised rising edge
   wire done_rise = done_s2_q && !done_s3_q;

   // raw word is stable while done is high; take it after sync
   logic [15:0] raw_s1_q, raw_s2_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         raw_s1_q <= 16'h0000;
         raw_s2_q <= 16'h0000;
      end else begin
         raw_s1_q <= core_raw;
         raw_s2_q <= raw_s1_q;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   // sequencer timers and start pulse
   logic [19:0] cnt_q, cnt_d;     // settle / conversion timer
   logic [19:0] per_q, per_d;     // start-to-start spacing
   logic        start_q, start_d;

   always_comb begin
      st_d     = st_q;
      cnt_d    = (cnt_q != 20'h00000) ? cnt_q - 20'h00001 : cnt_q;
      per_d    = (per_q != 20'h00000) ? per_q - 20'h00001 : per_q;
      start_d  = 1'b0;
      push     = 1'b0;
      sample_d = sample_q;
      if (!en || cfg_chg) begin
         // any new setting with enable set restarts the settling wait; one clearing enable goes to idle
         st_d  = en || cfg_chg ? ASC_SETTLE : ASC_IDLE;
         cnt_d = settle_cyc(asc_mode_t'(ctrl_d[`ASC_CTRL_MODE_LO +: 3]));
         if (!ctrl_d[`ASC_CTRL_EN]) st_d = ASC_IDLE;
      end else begin
         unique case (st_q)
            ASC_IDLE: begin
               st_d  = ASC_SETTLE;
               cnt_d = settle_cyc(mode_sel);
            end
            ASC_SETTLE: begin
               if (cnt_q == 20'h00000) begin
                  st_d = ASC_GAP;
               end
            end
            ASC_GAP: begin
               // hold off until spacing elapsed and room for a sample
               if (per_q == 20'h00000 && fifo_in_ready &&
                   !done_s2_q) begin
                  start_d = 1'b1;
                  per_d   = period_cyc(mode_sel);
                  cnt_d   = CONV_CYC;
                  st_d    = ASC_CONV;
               end
            end
            ASC_CONV: begin
               if (done_rise) begin
                  // the whole raw word becomes the sample
                  sample_d = raw_s2_q;
                  push     = 1'b1;
                  st_d     = ASC_GAP;
               end else if (cnt_q == 20'h00000) begin
                  st_d = ASC_GAP;
               end
            end
         endcase
      end
   end

   // sequencer state registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q     <= ASC_IDLE;
         cnt_q    <= 20'h00000;
         per_q    <= 20'h00000;
         start_q  <= 1'b0;
         sample_q <= 16'h0000;
      end else begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         per_q    <= per_d;
         start_q  <= start_d;
         sample_q <= sample_d;
      end
   end
   assign core_start = start_q;

   // overrun flag: conversion timeout; set wins over read clear
   // cleared at the edge that captures the status word, so a
   // timeout landing in the data phase is kept for the next read
   always_comb begin
      ovf_d = ovf_q;
      if (rd_go && haddr[7:0] == `ASC_OFF_STATUS) ovf_d = 1'b0;
      if (en && !cfg_chg && st_q == ASC_CONV && !done_rise &&
          cnt_q == 20'h00000)
         ovf_d = 1'b1;
   end
   // overrun register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ovf_q <= 1'b0;
      else          ovf_q <= ovf_d;
   end

   // ****************************************
   // sample buffer
   // ****************************************
   asc_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_data   (sample_d),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_dout),
      .out_valid (fifo_valid),
      .out_ready (data_rd),
      .flush     (cfg_chg)
   );
endmodule // asc_ctrl

// ===== asc_ctrl_sva.sv
// Purpose: port checks for asc_ctrl
// Assumes: one clock, async active-low reset
// Notes:   bind at the foot
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_ctrl_chk #(
   parameter int FIFO_DEPTH = 4,
   parameter int SETTLE0_US = 171
) (
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic                hready,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic [3:0]          core_ch_sel,
   input wire logic                core_ref_bg,
   input wire asc_pkg::asc_range_t core_range,
   input wire logic                core_start
);
   import asc_pkg::*;
   // shortest settling wait over all modes, in cycles
   localparam int SW_MIN = ((SETTLE0_US < `ASC_SET4_US) ? SETTLE0_US
                            : `ASC_SET4_US) * `ASC_CLK_MHZ;
   logic        wr_q, wr_d;
   logic [15:0] sw_q, sw_d, ss_q, ss_d;
   // ****************************************
   // helper counters
   // ****************************************
   // ctrl write data phase, cycles since write and since start
   always_comb begin
      wr_d = hsel & hready & htrans[1] & hwrite
             & (haddr[7:0] == `ASC_OFF_CTRL);
      sw_d = wr_q ? 16'h0000 : sw_q + {15'h0, sw_q != 16'hffff};
      ss_d = core_start ? 16'h0000 : ss_q + {15'h0, ss_q != 16'hffff};
   end
   // register only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         sw_q <= 16'hffff;
         ss_q <= 16'hffff;
      end else begin
         wr_q <= wr_d;
         sw_q <= sw_d;
         ss_q <= ss_d;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response");
   a_start_pulse: assert property (core_start |=> !core_start)
      else $error("start wider than one cycle");
   a_start_spacing: assert property (core_start |-> ss_q >= 16'd535)
      else $error("starts too close");
   a_settle_wait: assert property (core_start |-> sw_q >= SW_MIN)
      else $error("start before settling");
   a_chan_legal: assert property (core_ch_sel <= 4'h8)
      else $error("channel out of range");
   a_range_legal: assert property (core_range != 2'b11)
      else $error("illegal range code");
   a_sel_stable: assert property ($changed({core_ch_sel, core_ref_bg,
      core_range}) |-> $past(wr_q) || $past(wr_q, 2))
      else $error("select moved without write");
endmodule // asc_ctrl_chk

bind asc_ctrl asc_ctrl_chk #(
   .FIFO_DEPTH(FIFO_DEPTH),
   .SETTLE0_US(SETTLE0_US)
) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .core_ch_sel(core_ch_sel),
   .core_ref_bg(core_ref_bg), .core_range(core_range),
   .core_start(core_start));

// ===== asc_core_model.sv
// Purpose: behavioural analog converter core
// Assumes: lat between 1 and 1000
// Notes:   mute makes the core never answer
`timescale 1ns/1ps
module asc_core_model (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        core_start,
   input wire logic [3:0]  core_ch_sel,
   input wire logic [10:0] lat,
   input wire logic        mute,
   output logic            core_done,
   output logic [15:0]     core_raw
);
   logic [10:0] t_q;
   // answer lat cycles after start, hold 10 cycles, then release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t_q <= 11'h000;
         core_done <= 1'b0;
         core_raw <= 16'hffff;
      end else if (core_start && !mute) begin
         t_q <= 11'h001;
      end else if (t_q != 11'h000) begin
         t_q <= t_q + 11'h001;
         if (t_q == lat) begin
            core_done <= 1'b1;
            core_raw <= {12'ha50, core_ch_sel};
         end
         if (t_q == lat + 11'd10) begin
            core_done <= 1'b0;
            core_raw <= ~core_raw; // released word
            t_q <= 11'h000;
         end
      end
   end
endmodule // asc_core_model

// ===== asc_ctrl_test.sv
// Purpose: self-checking bench for asc_ctrl
// Assumes: 100 MHz hclk, mode0 settle shortened to 2 us
// Notes:   core model answers fast, slow or never
`timescale 1ns/1ps
`include "asc_defines.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
   mismatches++; $display("unexpected at %0t: %h %h", $time, a, e); end end
module asc_ctrl_test;
   import asc_pkg::*;
   logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]        haddr, hwdata, hrdata, rd;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   logic [3:0]         core_ch_sel;
   logic               core_ref_bg, core_start, core_done, mute;
   asc_range_t         core_range;
   logic [15:0]        core_raw;
   logic [10:0]        lat;
   int                 mismatches, comparisons, n, c;
   int settle_c[5] = '{200, 8500, 2100, 1100, 500};
   int period_c[5] = '{17068, 8547, 2134, 1067, 535};
   asc_ctrl #(.FIFO_DEPTH(4), .SETTLE0_US(2)) u_dut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .core_ch_sel(core_ch_sel), .core_ref_bg(core_ref_bg),
      .core_range(core_range), .core_start(core_start),
      .core_done(core_done), .core_raw(core_raw));
   asc_core_model u_core (.hclk(hclk), .hresetn(hresetn),
      .core_start(core_start), .core_ch_sel(core_ch_sel), .lat(lat),
      .mute(mute), .core_done(core_done), .core_raw(core_raw));
   // ****************************************
   // clock, bus tasks, closing
   // ****************************************
   // 10 ns clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // one single word transfer, called just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // count edges until core_start is seen
   task automatic wait_start();
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (core_start !== 1'b1 && n < 40000);
   endtask
   // counts and verdict
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (90000) @(posedge hclk);
      mismatches++;
      close_out();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, mute} = '0;
      hsize = 3'b010;
      lat = 11'd20;
      hresetn = 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      @(posedge hclk);
      bus(0, `ASC_OFF_CTRL, 0); `CHK(rd, `ASC_CTRL_RST)
      bus(0, `ASC_OFF_STATUS, 0); `CHK(rd, 32'h0)
      bus(0, `ASC_OFF_DATA, 0); `CHK(rd, 32'h0)
      bus(0, 8'h0c, 0); `CHK(rd, 32'h0)
      for (int i = 0; i < 10; i++) begin
         bus(1, `ASC_OFF_CTRL, (i << 4) | ((i % 3) << 8) | ((i & 1) << 10));
         @(posedge hclk);
         `CHK(core_ch_sel, (i > 8) ? 4'h8 : 4'(i))
         `CHK(core_range, 2'(i % 3))
         `CHK(core_ref_bg, 1'(i & 1))
      end
      $display("test selects done");
      for (int m = 0; m < 5; m++) begin
         bus(1, `ASC_OFF_CTRL, 32'h1 | (m << 1) | (m << 4));
         wait_start(); `CHK(n >= settle_c[m] && n < 40000, 1'b1)
         wait_start(); `CHK(n >= period_c[m] && n < 40000, 1'b1)
         bus(0, `ASC_OFF_DATA, 0); `CHK(rd, 32'ha500 | m)
      end
      $display("test modes done");
      lat <= 11'd900;
      bus(1, `ASC_OFF_CTRL, 32'h79);
      c = 0;
      do begin
         bus(0, `ASC_OFF_STATUS, 0);
         c++;
      end while (rd[1] !== 1'b1 && c < 3000);
      `CHK(rd[3:0], 4'b0011)
      repeat (1200) @(posedge hclk);
      for (int i = 0; i < 4; i++) begin
         bus(0, `ASC_OFF_DATA, 0); `CHK(rd, 32'ha507)
      end
      bus(0, `ASC_OFF_STATUS, 0); `CHK(rd[0], 1'b0)
      bus(0, `ASC_OFF_DATA, 0); `CHK(rd, 32'h0)
      $display("test fill done");
      mute <= 1'b1;
      bus(1, `ASC_OFF_CTRL, 32'h69);
      repeat (2500) @(posedge hclk);
      bus(0, `ASC_OFF_STATUS, 0); `CHK(rd[3], 1'b1)
      bus(0, `ASC_OFF_STATUS, 0); `CHK(rd[3], 1'b0)
      mute <= 1'b0;
      bus(1, `ASC_OFF_CTRL, 32'h0);
      c = 0;
      repeat (3000) begin
         @(posedge hclk);
         if (core_start === 1'b1) c++;
      end
      `CHK(c, 0)
      $display("test timeout and disable done");
      close_out();
   end
endmodule // asc_ctrl_test
